//--- uie_pkg.sv
// constants and types shared by the usart interrupt enable mask block
// assumes a 32-bit classic wishbone register bus with byte addresses
`default_nettype none
package uie_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int FLAG_W = 13;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_FLAGS = 8'h40;
  localparam logic [7:0] OFF_SET = 8'h44;
  localparam logic [7:0] OFF_CLEAR = 8'h48;
  localparam logic [7:0] OFF_ENABLE = 8'h4C;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and bit masks
  localparam logic [12:0] ENABLE_RST = 13'h0000;
  localparam logic [12:0] FLAG_RST = 13'h0000;
  localparam logic [12:0] ENABLE_MASK = 13'h1_FFF;
  // buffer level and data valid are live levels, not sticky
  localparam logic [12:0] STICKY_MASK = 13'h1_FF9;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [18:0] UPPER_ZERO = 19'h0_0000;

  ////////////////////////////////////////////////////////////////////////////
  // one bit per interrupt source, msb first (bit 12 down to bit 0)
  typedef struct packed {
    logic collision_check_fail;
    logic select_in_master;
    logic multiproc_address_frame;
    logic framing_error;
    logic parity_error;
    logic tx_underflow;
    logic tx_overflow;
    logic rx_underflow;
    logic rx_overflow;
    logic rx_buffer_full;
    logic rx_data_valid;
    logic tx_buffer_level;
    logic tx_complete;
  } uie_flags_s;

endpackage
`default_nettype wire

//--- uie_flag_bank.sv
// pending flag bank: sticky event flags with software set and clear
// assumes set, clear and events arrive on clk_i from the same domain
`default_nettype none
`timescale 1ns/10ps
module uie_flag_bank (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // sources
  input wire uie_pkg::uie_flags_s hw_set_i,
  input wire logic tx_buffer_level_i,
  input wire logic rx_data_valid_i,
  input wire logic [12:0] sw_set_i,
  input wire logic [12:0] sw_clr_i,
  // state
  output uie_pkg::uie_flags_s flags_o
);

  uie_pkg::uie_flags_s flags_q;
  uie_pkg::uie_flags_s next_flags;

  always_comb begin
    // [R16] clear on one
    next_flags = flags_q & ~(sw_clr_i & uie_pkg::STICKY_MASK);
    // [R17] set on one
    // set is ored after the clear so a same-cycle event is never lost
    next_flags = next_flags | (sw_set_i & uie_pkg::STICKY_MASK)
                 | (hw_set_i & uie_pkg::STICKY_MASK);
    next_flags.tx_buffer_level = tx_buffer_level_i;
    next_flags.rx_data_valid = rx_data_valid_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= uie_pkg::FLAG_RST;
    end else if (ce_i) begin
      flags_q <= next_flags;
    end
  end

  assign flags_o = flags_q;

endmodule
`default_nettype wire

//--- uie_irq_mask.sv
// usart interrupt enable mask with flag, set, clear and enable registers
// assumes a classic wishbone master and flag sources on clk_i
`default_nettype none
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R1] enable bit 12 gates collision check fail onto the request
// [R2] enable bit 11 gates select driven in master mode onto the request
// [R3] enable bit 10 gates multiprocessor address frame onto the request
// [R4] enable bit 9 gates framing error onto the request
// [R5] enable bit 8 gates parity error onto the request
// [R6] parity error never raises the request in synchronous operation
// [R7] enable bit 7 gates transmit underflow onto the request
// [R8] enable bit 6 gates transmit overflow onto the request
// [R9] enable bit 5 gates receive underflow onto the request
// [R10] enable bit 4 gates receive overflow onto the request
// [R11] enable bit 3 gates receive buffer full onto the request
// [R12] enable bit 2 gates receive data valid onto the request
// [R13] enable bit 1 gates transmit buffer level onto the request
// [R14] enable bit 0 gates transmit complete onto the request
// [R15] software writes zero to enable bits 31 to 13
// [R16] writing one to a clear bit clears that pending flag, except the live transmit buffer level and receive data valid bits
// [R17] writing one to a set bit sets that pending flag, except the live transmit buffer level and receive data valid bits
// [R18] request is high while any enabled flag is pending, except parity error in synchronous operation
module uie_irq_mask (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // flag sources
  input wire uie_pkg::uie_flags_s event_i,
  input wire logic tx_buffer_level_i,
  input wire logic rx_data_valid_i,
  input wire logic sync_mode_i,
  // interrupt
  output logic irq_o,
  output uie_pkg::uie_flags_s flags_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return m;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    logic h;
    h = (adr[7:2] == off[7:2]);
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake

  logic ack_q;
  logic next_ack;
  logic [31:0] rdata_q;
  logic [31:0] next_rdata;
  logic req_new;
  logic wr_fire;
  logic [31:0] lanes;
  logic [12:0] wmask;
  logic [12:0] ien_q;
  logic [12:0] next_ien;
  uie_pkg::uie_flags_s flags;

  // a request is answered once; ack drops the cycle after it is given
  assign req_new = wb_cyc_i & wb_stb_i & ~ack_q;
  // writes land at the edge where the master samples ack
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  // only lanes 0 and 1 carry implemented bits
  assign lanes = lane_mask(wb_sel_i);
  assign wmask = lanes[12:0];

  always_comb begin
    next_ack = 1'b0;
    next_rdata = rdata_q;
    if (req_new) begin
      next_ack = 1'b1;
      next_rdata = uie_pkg::RD_ZERO;
      if (!wb_we_i) begin
        if (hit(wb_adr_i, uie_pkg::OFF_FLAGS)) begin
          next_rdata = {uie_pkg::UPPER_ZERO, flags};
        end else if (hit(wb_adr_i, uie_pkg::OFF_ENABLE)) begin
          next_rdata = {uie_pkg::UPPER_ZERO, ien_q};
        end else begin
          // set, clear and unmapped words read as zero
          next_rdata = uie_pkg::RD_ZERO;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= uie_pkg::RD_ZERO;
    end else if (ce_i) begin
      ack_q <= next_ack;
      rdata_q <= next_rdata;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // enable mask register

  always_comb begin
    next_ien = ien_q;
    if (wr_fire && hit(wb_adr_i, uie_pkg::OFF_ENABLE)) begin
      // [R15] upper bits dropped
      // only the implemented bits are stored, upper bits read zero
      next_ien = ((ien_q & ~wmask) | (wb_dat_i[12:0] & wmask))
                 & uie_pkg::ENABLE_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien_q <= uie_pkg::ENABLE_RST;
    end else if (ce_i) begin
      ien_q <= next_ien;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending flags

  logic [12:0] sw_set;
  logic [12:0] sw_clr;

  always_comb begin
    sw_set = 13'h0000;
    sw_clr = 13'h0000;
    // [R17] software set
    if (wr_fire && hit(wb_adr_i, uie_pkg::OFF_SET)) begin
      sw_set = wb_dat_i[12:0] & wmask;
    end
    // [R16] software clear
    if (wr_fire && hit(wb_adr_i, uie_pkg::OFF_CLEAR)) begin
      sw_clr = wb_dat_i[12:0] & wmask;
    end
  end

  uie_flag_bank u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .hw_set_i(event_i),
    .tx_buffer_level_i(tx_buffer_level_i),
    .rx_data_valid_i(rx_data_valid_i),
    .sw_set_i(sw_set),
    .sw_clr_i(sw_clr),
    .flags_o(flags)
  );

  assign flags_o = flags;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt gating

  uie_pkg::uie_flags_s en;
  uie_pkg::uie_flags_s gated;

  assign en = ien_q;

  always_comb begin
    // [R1] collision check gate
    gated.collision_check_fail = flags.collision_check_fail
                                 & en.collision_check_fail;
    // [R2] master select gate
    gated.select_in_master = flags.select_in_master & en.select_in_master;
    // [R3] address frame gate
    gated.multiproc_address_frame = flags.multiproc_address_frame
                                    & en.multiproc_address_frame;
    // [R4] framing error gate
    gated.framing_error = flags.framing_error & en.framing_error;
    // [R5] parity error gate
    // [R6] async only parity
    // a parity flag left over from async use stays pending but silent
    gated.parity_error = flags.parity_error & en.parity_error
                         & ~sync_mode_i;
    // [R7] tx underflow gate
    gated.tx_underflow = flags.tx_underflow & en.tx_underflow;
    // [R8] tx overflow gate
    gated.tx_overflow = flags.tx_overflow & en.tx_overflow;
    // [R9] rx underflow gate
    gated.rx_underflow = flags.rx_underflow & en.rx_underflow;
    // [R10] rx overflow gate
    gated.rx_overflow = flags.rx_overflow & en.rx_overflow;
    // [R11] buffer full gate
    gated.rx_buffer_full = flags.rx_buffer_full & en.rx_buffer_full;
    // [R12] data valid gate
    gated.rx_data_valid = flags.rx_data_valid & en.rx_data_valid;
    // [R13] buffer level gate
    gated.tx_buffer_level = flags.tx_buffer_level & en.tx_buffer_level;
    // [R14] tx complete gate
    gated.tx_complete = flags.tx_complete & en.tx_complete;
  end

  // [R18] request combine
  assign irq_o = |gated;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  ccf_enabled_a: assert property ( // [R1]
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && event_i.collision_check_fail && en.collision_check_fail
     && !(wr_fire && hit(wb_adr_i, uie_pkg::OFF_ENABLE))) |=> irq_o)
    else $error("collision check fail did not raise irq");

  ccf_blocked_a: assert property ( // [R1]
    @(posedge clk_i) disable iff (rst_i)
    (!en.collision_check_fail && (flags == 13'h1000)) |-> !irq_o)
    else $error("masked collision check fail raised irq");

  ssm_enabled_a: assert property ( // [R2]
    @(posedge clk_i) disable iff (rst_i)
    (flags.select_in_master && en.select_in_master) |-> irq_o)
    else $error("master select flag did not raise irq");

  parity_error_sync_a: assert property ( // [R6]
    @(posedge clk_i) disable iff (rst_i)
    (sync_mode_i && ((flags & ien_q) == 13'h0100)) |-> !irq_o)
    else $error("parity error raised irq in synchronous mode");

  irq_idle_a: assert property ( // [R18]
    @(posedge clk_i) disable iff (rst_i)
    ((flags & ien_q) == 13'h0000) |-> !irq_o)
    else $error("irq high with nothing enabled and pending");

  clear_one_a: assert property ( // [R16]
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_fire && hit(wb_adr_i, uie_pkg::OFF_CLEAR)
     && wb_sel_i[0] && wb_dat_i[0] && !event_i.tx_complete)
    |=> !flags.tx_complete)
    else $error("clear write left tx complete pending");

  set_one_a: assert property ( // [R17]
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_fire && hit(wb_adr_i, uie_pkg::OFF_SET)
     && wb_sel_i[1] && wb_dat_i[12]) |=> flags.collision_check_fail)
    else $error("set write did not raise collision flag");

  enable_write_a: assert property ( // [R15]
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_fire && hit(wb_adr_i, uie_pkg::OFF_ENABLE)
     && (wb_sel_i == 4'hF)) |=> (ien_q == $past(wb_dat_i[12:0])))
    else $error("enable write not stored");

  ack_single_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_ack_o) |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  ack_timely_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

  multiproc_address_frame_enabled_a: assert property ( // [R3]
    @(posedge clk_i) disable iff (rst_i)
    (flags.multiproc_address_frame && en.multiproc_address_frame) |-> irq_o)
    else $error("address frame flag did not raise irq");

  framing_error_enabled_a: assert property ( // [R4]
    @(posedge clk_i) disable iff (rst_i)
    (flags.framing_error && en.framing_error) |-> irq_o)
    else $error("framing error flag did not raise irq");

  parity_error_async_a: assert property ( // [R5]
    @(posedge clk_i) disable iff (rst_i)
    (!sync_mode_i && flags.parity_error && en.parity_error) |-> irq_o)
    else $error("parity error flag did not raise irq");

  txc_enabled_a: assert property ( // [R14]
    @(posedge clk_i) disable iff (rst_i)
    (flags.tx_complete && en.tx_complete) |-> irq_o)
    else $error("tx complete flag did not raise irq");

  level_track_a: assert property ( // [R13]
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> (flags.tx_buffer_level == $past(tx_buffer_level_i)))
    else $error("buffer level flag does not follow its input");

  valid_track_a: assert property ( // [R12]
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> (flags.rx_data_valid == $past(rx_data_valid_i)))
    else $error("data valid flag does not follow its input");

endmodule
`default_nettype wire

//--- uie_irq_mask_test.sv
// self-checking bench for the usart interrupt enable mask block
// assumes uie_pkg and uie_irq_mask are compiled first; bench drives all ports
`timescale 1ns/10ps
`default_nettype none
module uie_irq_mask_test;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic tx_buffer_level_i, rx_data_valid_i, sync_mode_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, s;
  logic [31:0] wb_dat_i, wb_dat_o, rd, d;
  logic [12:0] fl, en, b, ev;
  uie_pkg::uie_flags_s event_i, flags_o;
  int n_fail = 0;
  int check_count = 0;
  int cyc_n = 0;

  uie_irq_mask dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_i(event_i),
    .tx_buffer_level_i(tx_buffer_level_i), .rx_data_valid_i(rx_data_valid_i),
    .sync_mode_i(sync_mode_i), .irq_o(irq_o), .flags_o(flags_o));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // a hung handshake must still reach the verdict
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_fail++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // parity term is masked off the request in synchronous operation
  function automatic logic f_irq(input logic [12:0] f, e, input logic sy);
    return |(f & e & (sy ? 13'h1_EFF : 13'h1_FFF));
  endfunction

  // classic cycle: hold until ack, take data, then drop for a cycle
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    // ack and read data are taken at the rising edge that samples ack
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic look();
    @(negedge clk_i);
    check("irq", 32'(irq_o), 32'(f_irq(fl, en, sync_mode_i)));
    check("flags", 32'(flags_o), 32'(fl));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, ce_i} = 2'b11;
    {wb_cyc_i, wb_stb_i, wb_we_i, tx_buffer_level_i} = 4'h0;
    {rx_data_valid_i, sync_mode_i} = 2'b00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    event_i = '0;
    fl = 13'h0000;
    en = 13'h0000;
    rd = $urandom(32'h90c09ee6);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    look();
    wb(1'b0, uie_pkg::OFF_ENABLE, 32'h0000_0000, 4'hF);
    check("enable reset", rd, 32'h0000_0000);
    // byte lanes 0 and 1 hold the enables; upper bits read zero
    repeat (8) begin
      d = $urandom & 32'h0000_1FFF;
      s = 4'($urandom);
      wb(1'b1, uie_pkg::OFF_ENABLE, d, s);
      if (s[0]) en[7:0] = d[7:0];
      if (s[1]) en[12:8] = d[12:8];
      wb(1'b0, uie_pkg::OFF_ENABLE, 32'h0000_0000, 4'hF);
      check("enable rw", rd, 32'(en));
    end
    foreach (d[i]) begin
      if (i > 2) continue;
      wb(1'b0, 8'h44 + 8'(i) * 8'h04 + (i == 2 ? 8'h38 : 8'h00), 0, 4'hF);
      check("write-only or unmapped read", rd, 32'h0000_0000);
    end
    // each source alone, gated by its own enable bit
    for (int i = 0; i < 13; i++) begin
      b = 13'h0001 << i;
      en = ~b;
      wb(1'b1, uie_pkg::OFF_ENABLE, 32'(en), 4'hF);
      @(posedge clk_i);
      if (i == 1) tx_buffer_level_i <= 1'b1;
      else if (i == 2) rx_data_valid_i <= 1'b1;
      else wb(1'b1, uie_pkg::OFF_SET, 32'(b), 4'hF);
      @(posedge clk_i);
      fl = b;
      look();
      en = b;
      wb(1'b1, uie_pkg::OFF_ENABLE, 32'(en), 4'hF);
      look();
      @(posedge clk_i);
      sync_mode_i <= 1'b1;
      look();
      @(posedge clk_i);
      sync_mode_i <= 1'b0;
      wb(1'b1, uie_pkg::OFF_CLEAR, 32'(~b), 4'hF);
      wb(1'b1, uie_pkg::OFF_FLAGS, 32'h0000_0000, 4'hF);
      wb(1'b0, uie_pkg::OFF_FLAGS, 32'h0000_0000, 4'hF);
      check("flags read", rd, 32'(fl));
      tx_buffer_level_i <= 1'b0;
      rx_data_valid_i <= 1'b0;
      wb(1'b1, uie_pkg::OFF_CLEAR, 32'(b), 4'hF);
      fl = 13'h0000;
      look();
    end
    // a frozen clock enable drops an event
    @(posedge clk_i);
    ce_i <= 1'b0;
    event_i <= 13'h1_000;
    @(posedge clk_i);
    ce_i <= 1'b1;
    event_i <= '0;
    look();
    // random hardware events, enables, clears and mode
    repeat (150) begin
      ev = 13'($urandom & $urandom & $urandom) & uie_pkg::STICKY_MASK;
      @(posedge clk_i);
      event_i <= ev;
      sync_mode_i <= 1'($urandom);
      @(posedge clk_i);
      event_i <= '0;
      fl = fl | ev;
      look();
      if ($urandom % 3 == 0) begin
        en = 13'($urandom);
        wb(1'b1, uie_pkg::OFF_ENABLE, 32'(en), 4'hF);
        d = $urandom;
        wb(1'b1, uie_pkg::OFF_CLEAR, d, 4'hF);
        fl = fl & ~d[12:0];
        look();
      end
    end
    // a mid-run reset returns enables and flags to zero
    wb(1'b1, uie_pkg::OFF_SET, 32'h0000_1FF9, 4'hF);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    fl = 13'h0000;
    en = 13'h0000;
    look();
    wb(1'b0, uie_pkg::OFF_ENABLE, 32'h0000_0000, 4'hF);
    check("enable after reset", rd, 32'h0000_0000);
    test_done();
  end
endmodule
`default_nettype wire
